/* File: pbk_pkg.sv */
package pbk_pkg;
  // bank shape
  localparam int FAST_N  = 8;
  localparam int SLOW_N  = 4;
  localparam int FDIV_W  = 14;
  localparam int FFRAC_W = 4;
  localparam int FDUTY_W = FDIV_W + FFRAC_W;
  localparam int CNT_W   = 24;
  localparam int SFRAC_W = 16;
  localparam int ADC_W   = 12;
  localparam int SYNC_W  = FAST_N + SLOW_N + 2;

  // timing
  localparam int CLK_HZ   = 200_000_000;
  localparam int FIX1_HZ  = 10_000;
  localparam int FIX2_HZ  = 1_000;
  localparam int FIX1_CYC = CLK_HZ / FIX1_HZ;
  localparam int FIX2_CYC = CLK_HZ / FIX2_HZ;
  // 200 MHz * 5 / 64 gives the 15.625 MHz slow timebase strobe
  localparam logic [6:0] STB_ADD = 7'h05;
  localparam int STB_W = 6;

  // limits and reset values
  localparam logic [CNT_W-1:0]   DIV_MIN   = 24'h000002;
  localparam logic [CNT_W-1:0]   SDIV_SCL  = 24'h010000;
  localparam logic [FDUTY_W-1:0] TRIM_RST  = 18'h00000;
  localparam logic [FDUTY_W-1:0] TRIM_MAX  = 18'h3ffff;

  // sync vector bit positions
  localparam int SY_SLOW = FAST_N;
  localparam int SY_REQ  = FAST_N + SLOW_N;
  localparam int SY_DIR  = FAST_N + SLOW_N + 1;

  typedef enum logic [2:0] {FN_NONE, FN_GPI, FN_GPO, FN_PWM, FN_OTHER} pbk_func_type;
  typedef enum logic [1:0] {MG_DISABLE, MG_TRISTATE, MG_TRACK, MG_FIXED} pbk_mode_type;

  typedef struct packed {
    pbk_func_type       func;
    logic               gpo_val;
    logic               gpo_od;
    logic [FDUTY_W-1:0] duty;
    logic [FDIV_W-1:0]  phase;
  } pbk_fast_cfg_type;

  typedef struct packed {
    logic               en;
    pbk_mode_type       mode;
    logic               inc_raises;
    logic               once;
    logic               ignore_faults;
    logic [FDUTY_W-1:0] fixed_duty;
    logic [ADC_W-1:0]   tgt_low;
    logic [ADC_W-1:0]   tgt_high;
    logic [ADC_W-1:0]   nominal;
  } pbk_mrg_cfg_type;

  typedef struct packed {
    logic             pwm_sel;
    logic [CNT_W-1:0] div;
    logic [CNT_W-1:0] duty;
  } pbk_slow_cfg_type;
endpackage : pbk_pkg

/* File: pbk_pwm_core.sv */
`timescale 1ns/1ps
module pbk_pwm_core (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [23:0] period,
  input  wire logic [23:0] high,
  input  wire logic [23:0] phase,
  input  wire logic [23:0] ref_cnt,
  output logic             wave,
  output logic             wrap
);
  typedef enum logic [1:0] {CS_IDLE, CS_SYNC, CS_RUN} pbk_cst_type;
  typedef struct packed {
    pbk_cst_type st;
    logic [23:0] cnt;
    logic [23:0] per;
    logic [23:0] hi;
    logic [23:0] ph;
    logic        wave;
  } pbk_core_type;

  pbk_core_type q_reg;
  pbk_core_type q_next;

  //////////////////////////////////////////////////////////////////////////////
  // period counter; new settings are only sampled at a boundary
  always_comb begin
    q_next = q_reg;
    wrap   = 1'b0;
    unique case (q_reg.st)
      CS_IDLE: begin
        q_next.wave = 1'b0;
        if (run) begin
          q_next.ph = phase;
          q_next.st = CS_SYNC;
          // a match on the enabling edge starts at once; waiting would cost a full reference wrap
          if (tick && ref_cnt == phase) begin
            q_next.per  = period;
            q_next.hi   = high;
            q_next.cnt  = 24'h000000;
            q_next.wave = (high != 24'h000000);
            q_next.st   = CS_RUN;
          end
        end
      end
      CS_SYNC: begin
        q_next.wave = 1'b0;
        if (!run) begin
          q_next.st = CS_IDLE;
        end else if (tick && ref_cnt == q_reg.ph) begin
          q_next.per  = period;
          q_next.hi   = high;
          q_next.cnt  = 24'h000000;
          q_next.wave = (high != 24'h000000);
          q_next.st   = CS_RUN;
        end
      end
      CS_RUN: begin
        if (!run) begin
          q_next.st   = CS_IDLE;
          q_next.wave = 1'b0;
        end else if (tick) begin
          if (q_reg.cnt == q_reg.per - 24'h000001) begin
            wrap = 1'b1;
            if (phase != q_reg.ph) begin
              // realign low rather than cut a pulse short
              q_next.ph   = phase;
              q_next.st   = CS_SYNC;
              q_next.wave = 1'b0;
            end else begin
              q_next.per  = period;
              q_next.hi   = high;
              q_next.cnt  = 24'h000000;
              q_next.wave = (high != 24'h000000);
            end
          end else begin
            q_next.cnt  = q_reg.cnt + 24'h000001;
            q_next.wave = ((q_reg.cnt + 24'h000001) < q_reg.hi);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign wave = q_reg.wave;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_boundary_restart;
    wrap && run |=> (q_reg.cnt == 24'h000000) || (q_reg.st == CS_SYNC);
  endproperty
  a_boundary_restart: assert property (p_boundary_restart) else $error("no restart at boundary");

  property p_hold_per;
    q_reg.st == CS_RUN && run && !wrap |=> q_reg.per == $past(q_reg.per);
  endproperty
  a_hold_per: assert property (p_hold_per) else $error("period changed mid cycle");
endmodule : pbk_pwm_core

/* File: pbk_pwm_bank.sv */
`timescale 1ns/1ps
// Function
// - fast channel period is an integer count of timebase cycles, divisor 2 to 16383.
// - fast channels pair up 1-2, 3-4, 5-6, 7-8, sharing one divisor.
// - fast duty steps in sixteenths of a timebase cycle.
// - unused fast pin is general I/O; as output it drives low from reset.
// - one pair pin may be pwm while its companion is a plain output.
// - enabling one fast channel enables an unconfigured companion as pwm too.
// - slow channel one runs at a fixed 10 kHz.
// - slow channel two runs at a fixed 1 kHz.
// - slow channels three and four divide the 15.625 MHz timebase by 2 to 2^24-1.
// - slow programmable duty steps by one 15.625 MHz timebase cycle.
// - below 238 Hz slow duty is a 16-bit fraction of the period.
// - each slow pin is either a general input or a pwm output.
// - each fast channel has a programmable phase over the full period.
// - closed-loop margining trims duty from measured rail until target is reached.
// - correction direction selects whether rail rises or falls with duty.
// - margining may be disabled or tri-state the pin when idle.
// - idle tracking holds the nominal rail; fixed mode outputs a constant duty.
// - margining is commanded by bus operation or by two input pins.
// - open-loop margining drives two open-drain pulls per rail.
// - options trim only once at power-up and mask faults while margining.
// - margin request pin puts enabled rails in margin, release leaves it.
// - direction pin selects low target when asserted, high target otherwise.
module pbk_pwm_bank #(
  parameter int FIX1_CYC = pbk_pkg::FIX1_CYC,
  parameter int FIX2_CYC = pbk_pkg::FIX2_CYC
) (
  input  wire logic                                 mclk,
  input  wire logic                                 rst_b,
  input  wire pbk_pkg::pbk_fast_cfg_type [7:0]      fast_cfg,
  input  wire logic [3:0][pbk_pkg::FDIV_W-1:0]      pair_div,
  input  wire pbk_pkg::pbk_mrg_cfg_type [7:0]       mrg_cfg,
  input  wire pbk_pkg::pbk_slow_cfg_type [3:0]      slow_cfg,
  input  wire logic                                 margin_src_pins,
  input  wire logic                                 op_margin_req,
  input  wire logic                                 op_margin_low,
  input  wire logic                                 margin_req_pin,
  input  wire logic                                 margin_dir_pin,
  input  wire logic [7:0][pbk_pkg::ADC_W-1:0]       rail_mv,
  input  wire logic [7:0]                           rail_valid,
  input  wire logic [7:0]                           rail_fault,
  input  wire logic [7:0]                           fast_pwm_channel_in,
  output logic [7:0]                                fast_pwm_channel_out,
  output logic [7:0]                                fast_pwm_channel_oe,
  input  wire logic [3:0]                           slow_pwm_in,
  output logic [3:0]                                slow_pwm_out,
  output logic [3:0]                                slow_pwm_oe,
  output logic [7:0]                                ol_up_out,
  output logic [7:0]                                ol_up_oe,
  output logic [7:0]                                ol_dn_out,
  output logic [7:0]                                ol_dn_oe,
  output logic [7:0]                                fast_gpi,
  output logic [3:0]                                slow_gpi,
  output logic [7:0]                                rail_fault_eff,
  output logic [7:0]                                trim_settled,
  output logic                                      margin_active,
  output logic                                      margin_low_sel
);
  typedef struct packed {
    logic [pbk_pkg::FDIV_W-1:0]       ref_cnt;
    logic [pbk_pkg::STB_W-1:0]        stb_acc;
    logic [pbk_pkg::SYNC_W-1:0]       s1;
    logic [pbk_pkg::SYNC_W-1:0]       s2;
    logic [pbk_pkg::SYNC_W-1:0]       s3;
    logic [pbk_pkg::SYNC_W-1:0]       gpi;
    logic [7:0][3:0]                  acc;
    logic [7:0][pbk_pkg::FDUTY_W-1:0] trim;
    logic [7:0]                       done;
    logic [7:0]                       settled;
    logic                             act;
    logic                             low;
    logic [7:0]                       fout;
    logic [7:0]                       foe;
    logic [3:0]                       sout;
    logic [3:0]                       soe;
    logic [7:0]                       ol_up;
    logic [7:0]                       ol_dn;
    logic [7:0]                       fault_eff;
  } pbk_bank_type;

  pbk_bank_type q_reg;
  pbk_bank_type q_next;

  logic [7:0]                       pwm_on;
  logic [7:0]                       closed;
  logic [7:0][pbk_pkg::FDUTY_W-1:0] duty_eff;
  logic [7:0][4:0]                  frac_sum;
  logic [7:0][23:0]                 fast_hi;
  logic [7:0]                       fast_wave;
  logic [7:0]                       fast_wrap;
  logic [3:0][23:0]                 slow_per;
  logic [3:0][23:0]                 slow_hi;
  logic [3:0]                       slow_tick;
  logic [3:0]                       slow_wave;
  logic [6:0]                       stb_sum;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [23:0] clamp_div(input logic [23:0] d);
    clamp_div = (d < pbk_pkg::DIV_MIN) ? pbk_pkg::DIV_MIN : d;
  endfunction : clamp_div

  function automatic logic [23:0] scale_duty(input logic [23:0] per, input logic [15:0] frac);
    logic [39:0] p;
    p = per * frac;
    scale_duty = p[39:16];
  endfunction : scale_duty

  //////////////////////////////////////////////////////////////////////////////
  // pin function, duty selection and sixteenth-step dither
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pwm_on[i] = (fast_cfg[i].func == pbk_pkg::FN_PWM)
                || (fast_cfg[i].func == pbk_pkg::FN_NONE
                    && fast_cfg[i ^ 1].func == pbk_pkg::FN_PWM);
      closed[i] = mrg_cfg[i].en && mrg_cfg[i].mode != pbk_pkg::MG_DISABLE;
      if (closed[i] && (q_reg.act || mrg_cfg[i].mode == pbk_pkg::MG_TRACK)) begin
        duty_eff[i] = q_reg.trim[i];
      end else if (closed[i] && mrg_cfg[i].mode == pbk_pkg::MG_FIXED) begin
        duty_eff[i] = mrg_cfg[i].fixed_duty;
      end else begin
        duty_eff[i] = fast_cfg[i].duty;
      end
      // fraction carried period to period: mean high time moves by 1/16 cycle
      frac_sum[i] = {1'b0, q_reg.acc[i]} + {1'b0, duty_eff[i][3:0]};
      fast_hi[i]  = {10'h000, duty_eff[i][17:4]} + {23'h000000, frac_sum[i][4]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slow channel periods and duty
  assign stb_sum = {1'b0, q_reg.stb_acc} + pbk_pkg::STB_ADD;

  always_comb begin
    slow_per[0]  = 24'(FIX1_CYC);
    slow_per[1]  = 24'(FIX2_CYC);
    slow_per[2]  = clamp_div(slow_cfg[2].div);
    slow_per[3]  = clamp_div(slow_cfg[3].div);
    slow_tick[0] = 1'b1;
    slow_tick[1] = 1'b1;
    slow_tick[2] = stb_sum[6];
    slow_tick[3] = stb_sum[6];
    for (int k = 0; k < 4; k++) begin
      if (k < 2 || slow_per[k] >= pbk_pkg::SDIV_SCL) begin
        slow_hi[k] = scale_duty(slow_per[k], slow_cfg[k].duty[15:0]);
      end else begin
        slow_hi[k] = slow_cfg[k].duty;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel counters
  for (genvar g = 0; g < 8; g++) begin : g_fast
    pbk_pwm_core u_core (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .tick    (1'b1),
      .run     (pwm_on[g]),
      .period  (clamp_div({10'h000, pair_div[g / 2]})),
      .high    (fast_hi[g]),
      .phase   ({10'h000, fast_cfg[g].phase}),
      .ref_cnt ({10'h000, q_reg.ref_cnt}),
      .wave    (fast_wave[g]),
      .wrap    (fast_wrap[g])
    );
  end

  for (genvar g = 0; g < 4; g++) begin : g_slow
    pbk_pwm_core u_core (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .tick    (slow_tick[g]),
      .run     (slow_cfg[g].pwm_sel),
      .period  (slow_per[g]),
      .high    (slow_hi[g]),
      .phase   (24'h000000),
      .ref_cnt (24'h000000),
      .wave    (slow_wave[g]),
      .wrap    ()
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: sync, margin command, trim loop, pin drive
  always_comb begin
    logic [pbk_pkg::ADC_W-1:0] tgt;
    logic                      up;
    logic                      dn;
    logic                      raise;
    logic                      lower;
    tgt    = '0;
    up     = 1'b0;
    dn     = 1'b0;
    raise  = 1'b0;
    lower  = 1'b0;
    q_next = q_reg;
    q_next.ref_cnt = q_reg.ref_cnt + 14'h0001;
    q_next.stb_acc = stb_sum[5:0];
    // three stages; a change is taken once stages two and three agree
    q_next.s1 = {margin_dir_pin, margin_req_pin, slow_pwm_in, fast_pwm_channel_in};
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
    for (int b = 0; b < pbk_pkg::SYNC_W; b++) begin
      if (q_reg.s2[b] == q_reg.s3[b]) begin
        q_next.gpi[b] = q_reg.s3[b];
      end
    end
    if (margin_src_pins) begin
      q_next.act = q_reg.gpi[pbk_pkg::SY_REQ];
      q_next.low = q_reg.gpi[pbk_pkg::SY_DIR];
    end else begin
      q_next.act = op_margin_req;
      q_next.low = op_margin_low;
    end
    for (int i = 0; i < 8; i++) begin
      if (fast_wrap[i]) begin
        q_next.acc[i] = frac_sum[i][3:0];
      end
      tgt = q_reg.act ? (q_reg.low ? mrg_cfg[i].tgt_low : mrg_cfg[i].tgt_high)
                      : mrg_cfg[i].nominal;
      up    = rail_mv[i] < tgt;
      dn    = rail_mv[i] > tgt;
      raise = mrg_cfg[i].inc_raises ? up : dn;
      lower = mrg_cfg[i].inc_raises ? dn : up;
      if (rail_valid[i] && closed[i]
          && (q_reg.act || (mrg_cfg[i].mode == pbk_pkg::MG_TRACK
                            && !(mrg_cfg[i].once && q_reg.done[i])))) begin
        q_next.settled[i] = !up && !dn;
        if (raise && q_reg.trim[i] != pbk_pkg::TRIM_MAX) begin
          q_next.trim[i] = q_reg.trim[i] + 18'h00001;
        end else if (lower && q_reg.trim[i] != pbk_pkg::TRIM_RST) begin
          q_next.trim[i] = q_reg.trim[i] - 18'h00001;
        end
        if (!q_reg.act && !up && !dn) begin
          q_next.done[i] = 1'b1;
        end
      end
      // pulls only while margining, each as an open drain
      q_next.ol_up[i] = mrg_cfg[i].en && q_reg.act && !q_reg.low;
      q_next.ol_dn[i] = mrg_cfg[i].en && q_reg.act && q_reg.low;
      q_next.fault_eff[i] = rail_fault[i]
                            && !(mrg_cfg[i].ignore_faults && mrg_cfg[i].en && q_reg.act);
      if (pwm_on[i]) begin
        q_next.fout[i] = fast_wave[i];
        q_next.foe[i]  = !(mrg_cfg[i].en && mrg_cfg[i].mode == pbk_pkg::MG_TRISTATE
                           && !q_reg.act);
      end else if (fast_cfg[i].func == pbk_pkg::FN_GPO) begin
        q_next.fout[i] = fast_cfg[i].gpo_od ? 1'b0 : fast_cfg[i].gpo_val;
        q_next.foe[i]  = fast_cfg[i].gpo_od ? !fast_cfg[i].gpo_val : 1'b1;
      end else begin
        q_next.fout[i] = 1'b0;
        q_next.foe[i]  = 1'b0;
      end
    end
    for (int k = 0; k < 4; k++) begin
      q_next.sout[k] = slow_cfg[k].pwm_sel && slow_wave[k];
      q_next.soe[k]  = slow_cfg[k].pwm_sel;
    end
  end

  // single state register; everything is cleared, pins come up low or released
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs from flops, except the pull drive levels, which are tied low
  assign fast_pwm_channel_out = q_reg.fout;
  assign fast_pwm_channel_oe  = q_reg.foe;
  assign slow_pwm_out         = q_reg.sout;
  assign slow_pwm_oe          = q_reg.soe;
  assign ol_up_out            = 8'h00;
  assign ol_up_oe             = q_reg.ol_up;
  assign ol_dn_out            = 8'h00;
  assign ol_dn_oe             = q_reg.ol_dn;
  assign fast_gpi             = q_reg.gpi[7:0];
  assign slow_gpi             = q_reg.gpi[pbk_pkg::SY_SLOW +: 4];
  assign rail_fault_eff       = q_reg.fault_eff;
  assign trim_settled         = q_reg.settled;
  assign margin_active        = q_reg.act;
  assign margin_low_sel       = q_reg.low;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_gpo_drive;
    fast_cfg[2].func == pbk_pkg::FN_GPO && !fast_cfg[2].gpo_od
      |=> fast_pwm_channel_oe[2] && fast_pwm_channel_out[2] == $past(fast_cfg[2].gpo_val);
  endproperty
  a_gpo_drive: assert property (p_gpo_drive) else $error("gpo pin not driven");

  property p_companion;
    fast_cfg[1].func == pbk_pkg::FN_NONE && fast_cfg[0].func == pbk_pkg::FN_PWM
      && !mrg_cfg[1].en |=> fast_pwm_channel_oe[1];
  endproperty
  a_companion: assert property (p_companion) else $error("companion not enabled");

  property p_tristate;
    pwm_on[4] && mrg_cfg[4].en && mrg_cfg[4].mode == pbk_pkg::MG_TRISTATE && !q_reg.act
      |=> !fast_pwm_channel_oe[4];
  endproperty
  a_tristate: assert property (p_tristate) else $error("idle pin not released");

  sequence s_req_held;
    margin_src_pins && margin_req_pin [*6];
  endsequence
  property p_pin_req;
    s_req_held |-> margin_active;
  endproperty
  a_pin_req: assert property (p_pin_req) else $error("pin request not followed");

  property p_op_low;
    (!margin_src_pins && op_margin_req && op_margin_low) [*2] |-> margin_low_sel && margin_active;
  endproperty
  a_op_low: assert property (p_op_low) else $error("low target not selected");

  property p_trim_up;
    rail_valid[4] && closed[4] && mrg_cfg[4].mode == pbk_pkg::MG_TRACK && !q_reg.act
      && !mrg_cfg[4].once && mrg_cfg[4].inc_raises && rail_mv[4] < mrg_cfg[4].nominal
      && q_reg.trim[4] != pbk_pkg::TRIM_MAX
      |=> q_reg.trim[4] == $past(q_reg.trim[4]) + 18'h00001;
  endproperty
  a_trim_up: assert property (p_trim_up) else $error("trim did not rise");

  property p_open_loop;
    mrg_cfg[4].en && q_reg.act |=> ol_up_oe[4] == !$past(q_reg.low) && ol_dn_oe[4] == $past(q_reg.low);
  endproperty
  a_open_loop: assert property (p_open_loop) else $error("open-loop pull wrong");
endmodule : pbk_pwm_bank

/* File: pbk_rc_model.sv */
`timescale 1ns/1ps
// rc filter plus rail sense: averages the pwm pin over a 64-cycle window
module pbk_rc_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic [11:0]      rail_mv,
  output logic             rail_valid
);
  logic [5:0] win_reg;
  logic [6:0] acc_reg;
  // a released pin leaves the node at mid level, so it counts as half high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      win_reg    <= 6'h00;
      acc_reg    <= 7'h00;
      rail_mv    <= 12'h000;
      rail_valid <= 1'b0;
    end else begin
      win_reg    <= win_reg + 6'h01;
      rail_valid <= (win_reg == 6'h3f);
      if (win_reg == 6'h3f) begin
        rail_mv <= {acc_reg[5:0], 6'h00};
        acc_reg <= 7'h00;
      end else begin
        acc_reg <= acc_reg + {6'h00, pin_oe ? pin_out : win_reg[0]};
      end
    end
  end
endmodule : pbk_rc_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  localparam int F1 = 20;
  localparam int F2 = 40;
  logic                            mclk, rst_b, msrc, oreq, olow, rpin, dpin, mact, mlow, mv;
  pbk_pkg::pbk_fast_cfg_type [7:0] fc;
  logic [3:0][13:0]                pdiv;
  pbk_pkg::pbk_mrg_cfg_type [7:0]  mc;
  pbk_pkg::pbk_slow_cfg_type [3:0] sc;
  logic [11:0]                     mmv, pins;
  logic [7:0]                      fin, fout, foe, fgpi, rfe, rflt, ulo, uloe, dlo, dloe, tset;
  logic [3:0]                      sin, sout, soe, sgpi;
  int                              miscompares, tests_run, cyc;
  assign pins = {sout, fout};
  pbk_pwm_bank #(.FIX1_CYC(F1), .FIX2_CYC(F2)) pbk_pwm_bank_i (.mclk(mclk), .rst_b(rst_b),
    .fast_cfg(fc), .pair_div(pdiv), .mrg_cfg(mc), .slow_cfg(sc), .margin_src_pins(msrc),
    .op_margin_req(oreq), .op_margin_low(olow), .margin_req_pin(rpin), .margin_dir_pin(dpin),
    .rail_mv({36'h0, mmv, 48'h0}), .rail_valid({3'h0, mv, 4'h0}), .rail_fault(rflt),
    .fast_pwm_channel_in(fin), .fast_pwm_channel_out(fout), .fast_pwm_channel_oe(foe),
    .slow_pwm_in(sin), .slow_pwm_out(sout), .slow_pwm_oe(soe), .ol_up_out(ulo), .ol_up_oe(uloe),
    .ol_dn_out(dlo), .ol_dn_oe(dloe), .fast_gpi(fgpi), .slow_gpi(sgpi), .rail_fault_eff(rfe),
    .trim_settled(tset), .margin_active(mact), .margin_low_sel(mlow));
  // the filter only ever sees channel 4, the margined rail
  pbk_rc_model pbk_rc_model_i (.mclk(mclk), .rst_b(rst_b), .pin_out(fout[4]), .pin_oe(foe[4]),
    .rail_mv(mmv), .rail_valid(mv));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  // high cycles over 16 periods: whole part each period plus one carry per sixteenth
  function automatic int duty_sum(input int h, input int f);
    duty_sum = 16 * h + f;
  endfunction : duty_sum
  // wait for a rising edge of one pin, bounded
  task automatic sync(input int i);
    int n;
    n = 0;
    while (pins[i] !== 1'b0 && n < 9000) begin @(negedge mclk); n++; end
    while (pins[i] !== 1'b1 && n < 9000) begin @(negedge mclk); n++; end
  endtask : sync
  // one period measured from a rise to the next rise
  task automatic meas(input int i, output int per, hi);
    logic lo;
    per = 0;
    hi = 0;
    lo = 1'b0;
    while (!(lo && pins[i] === 1'b1) && per < 9000) begin
      if (pins[i] === 1'b1) hi++;
      else lo = 1'b1;
      per++;
      @(negedge mclk);
    end
  endtask : meas
  task automatic final_report;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int d, h, f, e, per, hi, sum;
    void'($urandom(3099));
    {fc, pdiv, mc, sc, msrc, oreq, olow, rpin, dpin, rflt} = '0;
    fin = 8'($urandom);
    sin = 4'($urandom);
    rst_b = 1'b0;
    // phase is set before release so the first alignment is exact
    fc[0].func = pbk_pkg::FN_PWM;
    fc[0].duty = 18'h00030;
    fc[1].phase = 14'h0004;
    fc[1].duty = 18'h00020;
    fc[2].func = pbk_pkg::FN_GPO;
    fc[5].func = pbk_pkg::FN_GPI;
    pdiv[0] = 14'h000a;
    // later channels start with the reference too, so no scenario waits a full wrap
    fc[4].func = pbk_pkg::FN_PWM;
    fc[4].duty = 18'h00080;
    pdiv[2] = 14'h0010;
    fc[6].func = pbk_pkg::FN_PWM;
    fc[7].func = pbk_pkg::FN_GPO;
    fc[7].gpo_od = 1'b1;
    fc[7].gpo_val = 1'b1;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    check("gpo_low", {foe[2], fout[2]}, 2'b10);
    sync(0);
    per = 0;
    while (pins[1] !== 1'b1 && per < 100) begin @(negedge mclk); per++; end
    check("phase_lag", per, 4);
    sync(0);
    meas(0, per, hi);
    check("ch0", {per, hi}, {32'd10, 32'd3});
    sync(1);
    meas(1, per, hi);
    check("ch1", {per, hi}, {32'd10, 32'd2});
    // pair 3: pwm beside a released open-drain companion
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 3 : 3 + $urandom % 29;
      h = (i == 0) ? 1 : 1 + $urandom % (d - 2);
      f = (i == 0) ? 15 : $urandom % 16;
      pdiv[3] = 14'(d);
      fc[6].duty = 18'(h * 16 + f);
      sync(6);
      meas(6, per, hi);
      meas(6, per, hi);
      check("fast_period", per, d);
      sum = 0;
      for (int k = 0; k < 16; k++) begin
        meas(6, per, hi);
        sum += hi;
      end
      check("fast_duty_sum", sum, duty_sum(h, f));
      check("pair_gpo", {foe[7], fout[7]}, 2'b00);
    end
    check("gpi", {fgpi[5], sgpi[3], soe[3]}, {fin[5], sin[3], 1'b0});
    sc[0] = '{1'b1, 24'h000000, 24'h008000};
    sc[1] = '{1'b1, 24'h000000, 24'h008000};
    sc[2] = '{1'b1, 24'h000005, 24'h000002};
    for (int j = 0; j < 3; j++) begin
      e = (j == 0) ? F1 : (j == 1) ? F2 : 64;
      sync(8 + j);
      meas(8 + j, per, hi);
      meas(8 + j, per, hi);
      check("slow_period", per, e);
      if (j < 2) check("slow_high", hi, e / 2);
    end
    check("slow_tick_duty", (hi == 25 || hi == 26), 1'b1);
    mc[4].en = 1'b1;
    mc[4].mode = pbk_pkg::MG_TRISTATE;
    mc[4].ignore_faults = 1'b1;
    mc[4].tgt_low = 12'($urandom);
    mc[4].tgt_high = 12'($urandom);
    rflt = 8'h10;
    repeat (3) @(negedge mclk);
    check("idle", {foe[4], rfe[4], mact}, 3'b010);
    oreq = 1'b1;
    olow = 1'b1;
    repeat (2) @(negedge mclk);
    check("bus_margin", {mact, mlow, rfe[4]}, 3'b110);
    check("ol_pulls", {uloe[4], dloe[4], ulo, dlo}, {2'b01, 16'h0000});
    repeat (300) @(negedge mclk);
    check("margin_drive", foe[4], 1'b1);
    {msrc, rpin, dpin} = 3'b110;
    repeat (8) @(negedge mclk);
    check("pin_margin", {mact, mlow, uloe[4], dloe[4]}, 4'b1010);
    rpin = 1'b0;
    repeat (8) @(negedge mclk);
    check("pin_release", {mact, foe[4]}, 2'b00);
    mc[4].mode = pbk_pkg::MG_FIXED;
    mc[4].fixed_duty = 18'h00040;
    sync(4);
    meas(4, per, hi);
    meas(4, per, hi);
    check("fixed_duty", {per, hi}, {32'd16, 32'd4});
    // idle tracking: a nominal above full scale keeps trim climbing, zero lets it settle
    mc[4].mode = pbk_pkg::MG_TRACK;
    mc[4].inc_raises = 1'b1;
    mc[4].nominal = 12'hfff;
    repeat (640) @(negedge mclk);
    check("track_climb", tset[4], 1'b0);
    mc[4].nominal = 12'h000;
    repeat (4000) @(negedge mclk);
    check("track_hold", tset[4], 1'b1);
    final_report();
  end
endmodule : tb
